// ===== design/bto_pkg.sv
/*
 * Package for the bus timeout and bus error monitor: timing constants,
 * size and cycle state codes, status bit positions and the carrier structs.
 * Assumes a 100 MHz local bus clock.
 */
package bto_pkg;

   localparam int unsigned CLK_PERIOD_NS = 10;

   // Recommended timeouts, figures as printed
   localparam int unsigned LBT_DEFAULT_US = 8;
   localparam int unsigned VAT_DEFAULT_MS = 32;
   localparam int unsigned GVT_DEFAULT_US = 256;

   localparam int unsigned LBT_DEFAULT_CYC = LBT_DEFAULT_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned VAT_DEFAULT_CYC = VAT_DEFAULT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned GVT_DEFAULT_CYC = GVT_DEFAULT_US * 1000 / CLK_PERIOD_NS;

   localparam int unsigned TMR_W = 24;
   typedef logic [TMR_W-1:0] bto_cnt_t;

   localparam bto_cnt_t CNT_RESET = 24'h00_0000;

   // Host processor status bit positions
   localparam int unsigned ST_LBTO_BIT  = 7;
   localparam int unsigned ST_OFFB_BIT  = 8;
   localparam int unsigned ST_PAR_BIT   = 9;
   localparam int unsigned ST_UNID_BIT  = 10;
   localparam int unsigned ST_W         = 11;
   localparam logic [ST_W-1:0] ST_RESET = 11'h000;

   // Per-master cause flags
   typedef struct packed {
      logic lbto;     // local bus timeout
      logic vato;     // VMEbus access timeout
      logic gvto;     // global VMEbus timeout
      logic berr;     // VMEbus BERR*
      logic par;      // DRAM parity with checking on
      logic csrw;     // narrow write to control/status space
   } bto_cause_s;

   localparam bto_cause_s CAUSE_RESET = '0;

   // Local bus cycle description
   typedef struct packed {
      logic       start;     // granted master begins its cycle
      logic       vme_dec;   // address decodes to VMEbus space
      logic       csr_dec;   // address in local control/status space
      logic       wr;
      logic [1:0] size;      // 0 byte, 1 word, 2 long, 3 line
      logic       done;      // normal termination by the slave
   } bto_lcyc_s;

   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;

   typedef enum logic [1:0] {
      CY_IDLE  = 2'b00,
      CY_LOCAL = 2'b01,
      CY_VREQ  = 2'b11,
      CY_VXFER = 2'b10
   } bto_cyc_e;

endpackage

// ===== design/bto_timer.sv
/*
 * One watchdog timer: cleared when its interval starts, counts while running,
 * raises a one-cycle expiry pulse once per interval.
 * Assumes start, run and limit come from the same clock domain.
 */
`timescale 1ns/100ps
module bto_timer
   import bto_pkg::*;
(
   // Clock and reset
   input  wire logic     clk,
   input  wire logic     rst,
   input  wire logic     ce,
   // Control
   input  wire logic     start,
   input  wire logic     run,
   input  wire logic     enable,
   input  wire bto_cnt_t limit,
   // Result
   output logic          expire
);

   bto_cnt_t cnt_ff;
   bto_cnt_t nxt_cnt;
   logic     fired_ff;
   logic     nxt_fired;
   logic     hit;

   assign hit = enable && run && !fired_ff && !start && (cnt_ff >= limit - 24'h00_0001);

   always_comb begin
      nxt_cnt   = cnt_ff;
      nxt_fired = fired_ff;
      if (start) begin
         nxt_cnt   = CNT_RESET;   // RULE19
         nxt_fired = 1'b0;
      end else if (run && !fired_ff) begin
         nxt_cnt = cnt_ff + 24'h00_0001;
         if (hit) begin
            nxt_fired = 1'b1;     // RULE19
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff   <= CNT_RESET;
         fired_ff <= 1'b0;
      end else if (ce) begin
         cnt_ff   <= nxt_cnt;
         fired_ff <= nxt_fired;
      end
   end

   assign expire = hit && ce;

   expire_once_a: assert property (@(posedge clk) disable iff (rst)
      expire |=> !expire [*2]) else $error("timer expired twice"); // RULE19

endmodule

// ===== design/bto_monitor.sv
/*
 * Bus timeout and bus error monitor of a local-bus-to-VMEbus bridge.
 * Holds the local bus, VMEbus access and global VMEbus timers, the slave
 * side local timer, the error acknowledge logic and per-master status.
 * Assumes local bus inputs are synchronous to SYS_CLK; VMEbus strobes, DTACK
 * and BERR are asynchronous and resynchronised here; VME_BUS_GRANT is used unsynchronised.
 */
// Summary of operation
// RULE1 - Local timer starts when granted cycle begins
// RULE2 - Local timer stops on VMEbus address decode
// RULE3 - Software sets local timeout near 8 us
// RULE4 - Access timer runs from request to grant
// RULE5 - Access timeout large, infinite setting allowed
// RULE6 - Global timer spans data strobe active period
// RULE7 - Global timer near 256 us, can disable
// RULE8 - Software sets global timeout above transfers
// RULE9 - Slave access requests bus, starts local timer
// RULE10 - Slave ack drives DTACK; DTACK gives ack
// RULE11 - Error ack on timeout, parity, VMEbus error
// RULE12 - Flag local timeout; VMEbus cycles excluded
// RULE13 - Flag access timeout when grant too late
// RULE14 - Report BERR during own VMEbus access
// RULE15 - Narrow writes to control space error
// RULE16 - Status bits per master identify cause
// RULE17 - Offboard error sets processor status bit 8
// RULE18 - Local timeout sets processor status bit 7
// RULE19 - Timers clear per interval, expire once
`timescale 1ns/100ps
module bto_monitor
   import bto_pkg::*;
#(
   parameter int unsigned NMST = 4,
   parameter int unsigned CPU_ID = 0,
   parameter bto_cnt_t   VAT_LIMIT_RST = bto_cnt_t'(VAT_DEFAULT_CYC),
   parameter bto_cnt_t   LBT_LIMIT_RST = bto_cnt_t'(LBT_DEFAULT_CYC),
   parameter bto_cnt_t   GVT_LIMIT_RST = bto_cnt_t'(GVT_DEFAULT_CYC)
)
(
   // Clock and reset
   input  wire logic                    SYS_CLK,
   input  wire logic                    RST,
   input  wire logic                    CE,
   // Timer and parity check configuration
   input  wire bto_cnt_t                LBT_LIMIT,
   input  wire bto_cnt_t                VAT_LIMIT,
   input  wire logic                    VAT_INFINITE,
   input  wire bto_cnt_t                GVT_LIMIT,
   input  wire logic                    GVT_ENABLE,
   input  wire logic                    PARITY_CHECK_EN,
   // Local bus master cycle
   input  wire bto_lcyc_s               LCYC,
   input  wire logic [$clog2(NMST)-1:0] LMASTER,
   input  wire logic                    DRAM_PAR_ERR,
   output logic                         TRANSFER_ACK,
   output logic                         TRANSFER_ERROR_ACK,
   // VMEbus master side
   output logic                         VME_BUS_REQ,
   input  wire logic                    VME_BUS_GRANT,
   input  wire logic                    VME_DS0_N,
   input  wire logic                    VME_DS1_N,
   input  wire logic                    VME_DTACK_N,
   input  wire logic                    VME_BERR_N,
   // VMEbus slave side
   input  wire logic                    SLV_DECODE,
   output logic                         SLV_LBUS_REQ,
   input  wire logic                    SLV_LBUS_GRANT,
   input  wire logic                    SLV_MEM_ACK,
   output logic                         VME_DTACK_OUT_N,
   output logic                         VME_DTACK_OE,
   // Status
   output bto_cause_s [NMST-1:0]        CAUSE,
   input  wire logic [NMST-1:0]         CAUSE_CLR,
   output logic [ST_W-1:0]              CPU_STATUS,
   input  wire logic                    CPU_STATUS_CLR
);

   // Three-stage synchronisers for the VMEbus strobe, DTACK and BERR pins
   logic [2:0] ds_sync_ff, dtack_sync_ff, berr_sync_ff;
   logic [2:0] nxt_ds_sync, nxt_dtack_sync, nxt_berr_sync;
   logic       ds_act_ff, dtack_act_ff, berr_act_ff;
   logic       nxt_ds_act, nxt_dtack_act, nxt_berr_act;

   always_comb begin
      nxt_ds_sync    = {ds_sync_ff[1:0], ~(VME_DS0_N & VME_DS1_N)};
      nxt_dtack_sync = {dtack_sync_ff[1:0], ~VME_DTACK_N};
      nxt_berr_sync  = {berr_sync_ff[1:0], ~VME_BERR_N};
      // A change counts only once the last two stages agree
      nxt_ds_act    = (ds_sync_ff[2] == ds_sync_ff[1]) ? ds_sync_ff[2] : ds_act_ff;
      nxt_dtack_act = (dtack_sync_ff[2] == dtack_sync_ff[1]) ? dtack_sync_ff[2] : dtack_act_ff;
      nxt_berr_act  = (berr_sync_ff[2] == berr_sync_ff[1]) ? berr_sync_ff[2] : berr_act_ff;
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ds_sync_ff    <= 3'h0;
         dtack_sync_ff <= 3'h0;
         berr_sync_ff  <= 3'h0;
         ds_act_ff     <= 1'b0;
         dtack_act_ff  <= 1'b0;
         berr_act_ff   <= 1'b0;
      end else if (CE) begin
         ds_sync_ff    <= nxt_ds_sync;
         dtack_sync_ff <= nxt_dtack_sync;
         berr_sync_ff  <= nxt_berr_sync;
         ds_act_ff     <= nxt_ds_act;
         dtack_act_ff  <= nxt_dtack_act;
         berr_act_ff   <= nxt_berr_act;
      end
   end

   // Master cycle sequencer
   bto_cyc_e cyc_ff, nxt_cyc;
   logic     ds_prev_ff, nxt_ds_prev;
   logic     lbt_exp, vat_exp, gvt_exp, slt_exp;
   logic     narrow_csr_wr, par_fault, err_now, ack_now;

   assign narrow_csr_wr = LCYC.csr_dec && LCYC.wr &&
                          (LCYC.size == SZ_BYTE || LCYC.size == SZ_WORD);
   assign par_fault     = DRAM_PAR_ERR && PARITY_CHECK_EN;

   always_comb begin
      nxt_cyc     = cyc_ff;
      nxt_ds_prev = ds_act_ff;
      err_now     = 1'b0;
      ack_now     = 1'b0;
      unique case (cyc_ff)
         CY_IDLE: begin
            if (LCYC.start) begin
               nxt_cyc = LCYC.vme_dec ? CY_VREQ : CY_LOCAL;
               if (narrow_csr_wr) begin
                  err_now = 1'b1;     // RULE15
                  nxt_cyc = CY_IDLE;
               end
            end
         end
         CY_LOCAL: begin
            if (LCYC.vme_dec) begin
               nxt_cyc = CY_VREQ;     // RULE2
            end else if (lbt_exp || par_fault) begin
               err_now = 1'b1;        // RULE11
               nxt_cyc = CY_IDLE;
            end else if (LCYC.done) begin
               ack_now = 1'b1;
               nxt_cyc = CY_IDLE;
            end
         end
         CY_VREQ: begin
            if (vat_exp) begin
               err_now = 1'b1;        // RULE13
               nxt_cyc = CY_IDLE;
            end else if (VME_BUS_GRANT) begin
               nxt_cyc = CY_VXFER;
            end
         end
         CY_VXFER: begin
            if (berr_act_ff || gvt_exp) begin
               err_now = 1'b1;        // RULE14
               nxt_cyc = CY_IDLE;
            end else if (dtack_act_ff) begin
               ack_now = 1'b1;        // RULE10
               nxt_cyc = CY_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cyc_ff     <= CY_IDLE;
         ds_prev_ff <= 1'b0;
      end else if (CE) begin
         cyc_ff     <= nxt_cyc;
         ds_prev_ff <= nxt_ds_prev;
      end
   end

   assign TRANSFER_ACK       = ack_now && CE;
   assign TRANSFER_ERROR_ACK = err_now && CE;
   assign VME_BUS_REQ        = (cyc_ff == CY_VREQ);

   // Timers
   logic lbt_start, lbt_run, vat_start, vat_run, gvt_start;

   assign lbt_start = (cyc_ff == CY_IDLE) && LCYC.start && !LCYC.vme_dec; // RULE1
   assign lbt_run   = (cyc_ff == CY_LOCAL) && !LCYC.vme_dec;             // RULE2 RULE12
   assign vat_start = (nxt_cyc == CY_VREQ) && (cyc_ff != CY_VREQ);
   assign vat_run   = (cyc_ff == CY_VREQ) && !VME_BUS_GRANT;             // RULE4
   assign gvt_start = ds_act_ff && !ds_prev_ff;                          // RULE6

   bto_timer u_lbt (
      .clk    (SYS_CLK),
      .rst    (RST),
      .ce     (CE),
      .start  (lbt_start),
      .run    (lbt_run),
      .enable (1'b1),
      .limit  (LBT_LIMIT),
      .expire (lbt_exp)
   );

   bto_timer u_vat (
      .clk    (SYS_CLK),
      .rst    (RST),
      .ce     (CE),
      .start  (vat_start),
      .run    (vat_run),
      .enable (!VAT_INFINITE),    // RULE5
      .limit  (VAT_LIMIT),
      .expire (vat_exp)
   );

   bto_timer u_gvt (
      .clk    (SYS_CLK),
      .rst    (RST),
      .ce     (CE),
      .start  (gvt_start),
      .run    (ds_act_ff),        // RULE6
      .enable (GVT_ENABLE),       // RULE7
      .limit  (GVT_LIMIT),
      .expire (gvt_exp)
   );

   // Slave side: own local bus request and timer for an incoming access
   logic slv_req_ff, nxt_slv_req, slv_run_ff, nxt_slv_run, slv_dtack_ff, nxt_slv_dtack;

   always_comb begin
      nxt_slv_req   = slv_req_ff;
      nxt_slv_run   = slv_run_ff;
      nxt_slv_dtack = slv_dtack_ff;
      if (SLV_DECODE && !slv_req_ff && !slv_dtack_ff) begin
         nxt_slv_req = 1'b1;                    // RULE9
      end
      if (slv_req_ff && SLV_LBUS_GRANT && !slv_run_ff) begin
         nxt_slv_run = 1'b1;                    // RULE9
      end
      if (slv_run_ff && (SLV_MEM_ACK || slt_exp)) begin
         nxt_slv_req   = 1'b0;
         nxt_slv_run   = 1'b0;
         nxt_slv_dtack = SLV_MEM_ACK;           // RULE10
      end
      // Hold DTACK until the remote master drops its strobes
      if (slv_dtack_ff && !ds_act_ff) begin
         nxt_slv_dtack = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         slv_req_ff   <= 1'b0;
         slv_run_ff   <= 1'b0;
         slv_dtack_ff <= 1'b0;
      end else if (CE) begin
         slv_req_ff   <= nxt_slv_req;
         slv_run_ff   <= nxt_slv_run;
         slv_dtack_ff <= nxt_slv_dtack;
      end
   end

   bto_timer u_slt (
      .clk    (SYS_CLK),
      .rst    (RST),
      .ce     (CE),
      .start  (slv_req_ff && SLV_LBUS_GRANT && !slv_run_ff),
      .run    (slv_run_ff),
      .enable (1'b1),
      .limit  (LBT_LIMIT),
      .expire (slt_exp)
   );

   assign SLV_LBUS_REQ    = slv_req_ff;
   assign VME_DTACK_OUT_N = 1'b0;
   assign VME_DTACK_OE    = slv_dtack_ff;

   // Cause status per master; a new event beats a clear in the same cycle
   bto_cause_s [NMST-1:0] cause_ff, nxt_cause;
   logic [ST_W-1:0]        cpu_st_ff, nxt_cpu_st;
   bto_cause_s             ev;

   always_comb begin
      ev      = CAUSE_RESET;
      ev.lbto = (cyc_ff == CY_LOCAL) && lbt_exp;
      ev.vato = (cyc_ff == CY_VREQ) && vat_exp;
      ev.gvto = (cyc_ff == CY_VXFER) && gvt_exp;
      ev.berr = (cyc_ff == CY_VXFER) && berr_act_ff && !gvt_exp;
      ev.par  = (cyc_ff == CY_LOCAL) && par_fault && !lbt_exp && !LCYC.vme_dec;
      ev.csrw = (cyc_ff == CY_IDLE) && LCYC.start && narrow_csr_wr;
      nxt_cause = cause_ff;
      for (int m = 0; m < NMST; m++) begin
         if (CAUSE_CLR[m]) begin
            nxt_cause[m] = CAUSE_RESET;
         end
         if (LMASTER == m[$clog2(NMST)-1:0] && err_now) begin
            nxt_cause[m] = nxt_cause[m] | ev;   // RULE16
         end
      end
      nxt_cpu_st = CPU_STATUS_CLR ? ST_RESET : cpu_st_ff;
      if (err_now && LMASTER == CPU_ID[$clog2(NMST)-1:0]) begin
         if (ev.lbto) begin
            nxt_cpu_st[ST_LBTO_BIT] = 1'b1;     // RULE18
         end
         if (ev.vato || ev.gvto || ev.berr) begin
            nxt_cpu_st[ST_OFFB_BIT] = 1'b1;     // RULE17
         end
         if (ev.par) begin
            nxt_cpu_st[ST_PAR_BIT] = 1'b1;
         end
         if (ev == CAUSE_RESET) begin
            nxt_cpu_st[ST_UNID_BIT] = 1'b1;
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cause_ff  <= {NMST{CAUSE_RESET}};
         cpu_st_ff <= ST_RESET;
      end else if (CE) begin
         cause_ff  <= nxt_cause;
         cpu_st_ff <= nxt_cpu_st;
      end
   end

   assign CAUSE      = cause_ff;
   assign CPU_STATUS = cpu_st_ff;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   lbt_stops_vme_a: assert property (CE && cyc_ff == CY_LOCAL && LCYC.vme_dec
      |-> !lbt_exp && !TRANSFER_ERROR_ACK) else $error("local timer ran on VMEbus cycle"); // RULE2
   req_held_a: assert property (CE && cyc_ff == CY_VREQ && !VME_BUS_GRANT && !vat_exp
      |=> VME_BUS_REQ || !CE) else $error("bus request dropped early"); // RULE4
   vat_infinite_a: assert property (VAT_INFINITE |-> !vat_exp) else $error("infinite access timer expired"); // RULE5
   gvt_off_a: assert property (!GVT_ENABLE |-> !gvt_exp) else $error("disabled global timer expired"); // RULE7
   lbto_tea_a: assert property (CE && cyc_ff == CY_LOCAL && lbt_exp && !LCYC.vme_dec
      |-> TRANSFER_ERROR_ACK) else $error("local timeout without error ack"); // RULE11
   vato_err_a: assert property (CE && cyc_ff == CY_VREQ && vat_exp
      |-> TRANSFER_ERROR_ACK ##1 (cyc_ff == CY_IDLE)) else $error("access timeout not reported"); // RULE13
   berr_err_a: assert property (CE && cyc_ff == CY_VXFER && berr_act_ff
      |-> TRANSFER_ERROR_ACK && !TRANSFER_ACK) else $error("BERR not reported"); // RULE14
   csr_narrow_a: assert property (CE && cyc_ff == CY_IDLE && LCYC.start && narrow_csr_wr
      |-> TRANSFER_ERROR_ACK) else $error("narrow control write not refused"); // RULE15
   dtack_drive_a: assert property (CE && slv_run_ff && SLV_MEM_ACK
      |=> VME_DTACK_OE) else $error("DTACK not driven"); // RULE10
   lbto_stat_a: assert property (CE && ev.lbto && err_now && LMASTER == CPU_ID[$clog2(NMST)-1:0]
      |=> CPU_STATUS[ST_LBTO_BIT] && cause_ff[$past(LMASTER)].lbto) else $error("bit 7 not set"); // RULE18 RULE16
   offb_stat_a: assert property (CE && (ev.vato || ev.berr) && err_now
      && LMASTER == CPU_ID[$clog2(NMST)-1:0]
      |=> CPU_STATUS[ST_OFFB_BIT]) else $error("bit 8 not set"); // RULE17

   cov_local_ok: cover property (cyc_ff == CY_LOCAL ##1 TRANSFER_ACK);
   cov_vme_ok: cover property (cyc_ff == CY_VXFER && TRANSFER_ACK);
   cov_slave: cover property (VME_DTACK_OE);
   cov_vato: cover property (vat_exp);

endmodule

// ===== verif/bto_vme_far.sv
/*
 * Far side model: VMEbus arbiter, remote slave and the data strobes.
 * Assumes the monitor requests the bus and ends each cycle with an ack pulse.
 */
`timescale 1ns/100ps
module bto_vme_far (
   // Clock and reset
   input  wire logic   clk,
   input  wire logic   rst,
   // Monitor side
   input  wire logic   bus_req,
   input  wire logic   xfer_end,
   // Scenario control, a delay of 0 means never; nets need a 4-state type
   input  wire integer grant_dly,
   input  wire integer dtack_dly,
   input  wire logic   give_berr,
   input  wire logic   use_ds1,
   input  wire logic   slv_ds,
   // VMEbus lines; strobes, DTACK and BERR pulled up when released
   output logic        grant,
   output logic        ds0_n,
   output logic        ds1_n,
   output logic        dtack_n,
   output logic        berr_n
);
   int   gcnt;
   int   dcnt;
   logic ds;

   assign ds0_n = !((ds && !use_ds1) || slv_ds);
   assign ds1_n = !(ds && use_ds1);

   always @(posedge clk or posedge rst) begin
      if (rst || xfer_end) begin
         gcnt    <= 0;
         dcnt    <= 0;
         ds      <= 1'b0;
         grant   <= 1'b0;
         dtack_n <= 1'b1;
         berr_n  <= 1'b1;
      end else begin
         if (bus_req && !grant)
            gcnt <= gcnt + 1;
         if (bus_req && grant_dly > 0 && gcnt + 1 >= grant_dly)
            grant <= 1'b1;
         // Strobes stay low until the monitor ends the cycle
         if (grant)
            ds <= 1'b1;
         if (ds)
            dcnt <= dcnt + 1;
         if (ds && dcnt + 1 == dtack_dly && give_berr)
            berr_n <= 1'b0;
         if (ds && dcnt + 1 == dtack_dly && !give_berr)
            dtack_n <= 1'b0;
      end
   end
endmodule

// ===== verif/tb.sv
/*
 * Self-checking bench for the bus timeout and bus error monitor.
 * Assumes the far side model above and inputs driven at the falling edge.
 */
`timescale 1ns/100ps
module tb;
   import bto_pkg::*;
   localparam int LBT = 20;
   localparam int VAT = 40;
   localparam int GVT = 30;
   logic            clk, rst, vat_inf, gvt_en, par_en, par_err, cpu_clr, ce;
   logic            ack, transfer_error_ack, breq, grant, ds0_n, ds1_n, far_dtack_n, dtack_n, berr_n;
   logic            slv_dec, slv_req, slv_gnt, slv_ack, dt_out_n, dt_oe, slv_ds, bm, d1;
   bto_lcyc_s       lcyc;
   logic [1:0]      lmst;
   bto_cause_s [3:0] cause;
   logic [3:0]      cause_clr;
   logic [ST_W-1:0] cpu_st;
   int              grant_dly, dtack_dly, failures, n_compared, cycles, ack_at, tea_at;

   // Wired DTACK: pulled up, low when either board drives it
   assign dtack_n = far_dtack_n & ~(dt_oe & ~dt_out_n);

   bto_monitor dut (.SYS_CLK(clk), .RST(rst), .CE(ce),
      .LBT_LIMIT(bto_cnt_t'(LBT)), .VAT_LIMIT(bto_cnt_t'(VAT)), .VAT_INFINITE(vat_inf),
      .GVT_LIMIT(bto_cnt_t'(GVT)), .GVT_ENABLE(gvt_en), .PARITY_CHECK_EN(par_en),
      .LCYC(lcyc), .LMASTER(lmst), .DRAM_PAR_ERR(par_err), .TRANSFER_ACK(ack),
      .TRANSFER_ERROR_ACK(transfer_error_ack), .VME_BUS_REQ(breq), .VME_BUS_GRANT(grant),
      .VME_DS0_N(ds0_n), .VME_DS1_N(ds1_n), .VME_DTACK_N(dtack_n), .VME_BERR_N(berr_n),
      .SLV_DECODE(slv_dec), .SLV_LBUS_REQ(slv_req), .SLV_LBUS_GRANT(slv_gnt),
      .SLV_MEM_ACK(slv_ack), .VME_DTACK_OUT_N(dt_out_n), .VME_DTACK_OE(dt_oe),
      .CAUSE(cause), .CAUSE_CLR(cause_clr), .CPU_STATUS(cpu_st), .CPU_STATUS_CLR(cpu_clr));

   bto_vme_far far (.clk(clk), .rst(rst), .bus_req(breq), .xfer_end(ack | transfer_error_ack),
      .grant_dly(grant_dly), .dtack_dly(dtack_dly), .give_berr(bm), .use_ds1(d1),
      .slv_ds(slv_ds), .grant(grant), .ds0_n(ds0_n), .ds1_n(ds1_n),
      .dtack_n(far_dtack_n), .berr_n(berr_n));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end

   task stop_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task chk_vec(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   task chk_rng(input string nm, input int lo, input int hi, input int g);
      n_compared++;
      if (g < lo || g > hi) begin
         failures++;
         $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask

   // One local cycle; records the cycle index of the first ack or error ack
   task run_cyc(input logic [1:0] m, input logic v, input logic c, input logic [1:0] sz,
                input int done_at, input int lim);
      ack_at = -1;
      tea_at = -1;
      @(negedge clk);
      lmst = m;
      lcyc = '{1'b1, v, c, c, sz, 1'b0};
      for (int i = 0; i < lim && ack_at < 0 && tea_at < 0; i++) begin
         if (i > 0) begin
            @(negedge clk);
            lcyc.start = 1'b0;
         end
         lcyc.done = (i == done_at);
         #2;
         if (ack === 1'b1)
            ack_at = i;
         if (transfer_error_ack === 1'b1)
            tea_at = i;
      end
      @(negedge clk);
      lcyc = '0;
   endtask

   // Status is sticky, so every error scenario ends with a clear
   task chk_err(input logic [31:0] ec, input logic [31:0] es);
      chk_vec("cause", ec, 32'(cause));
      chk_vec("status", es, 32'(cpu_st));
      @(negedge clk);
      cause_clr = '1;
      cpu_clr = 1'b1;
      @(negedge clk);
      cause_clr = '0;
      cpu_clr = 1'b0;
      @(negedge clk);
      chk_vec("cleared", 32'h0, 32'(cause) | 32'(cpu_st));
   endtask

   task t_local;
      run_cyc(2'h0, 1'b0, 1'b0, 2'h2, 5, 60);
      chk_rng("local_ack", 5, 5, ack_at);
      chk_rng("local_tea", -1, -1, tea_at);
      run_cyc(2'h0, 1'b0, 1'b0, 2'h2, -1, 60);
      chk_rng("lbto_at", LBT, LBT, tea_at);
      chk_err(32'h20, 32'(1) << ST_LBTO_BIT);
      run_cyc(2'h1, 1'b0, 1'b0, 2'h2, -1, 60);
      chk_rng("lbto_m1", LBT, LBT, tea_at);
      chk_err(32'h800, 32'h0);
   endtask

   // Five edges with the enable low must push the timeout back by five cycles
   task t_ce;
      fork
         run_cyc(2'h0, 1'b0, 1'b0, 2'h2, -1, 60);
         begin
            repeat (5) @(negedge clk);
            ce = 1'b0;
            repeat (5) @(negedge clk);
            ce = 1'b1;
         end
      join
      chk_rng("ce_hold", LBT + 5, LBT + 5, tea_at);
      chk_err(32'h20, 32'(1) << ST_LBTO_BIT);
   endtask

   task t_vme;
      grant_dly = 30;
      dtack_dly = 5;
      // Grant comes after the local limit, so the local timer must be stopped
      run_cyc(2'h0, 1'b1, 1'b0, 2'h2, -1, 200);
      chk_rng("vme_tea", -1, -1, tea_at);
      chk_rng("vme_ack", 35, 60, ack_at);
      chk_err(32'h0, 32'h0);
      grant_dly = 0;
      run_cyc(2'h0, 1'b1, 1'b0, 2'h2, -1, 200);
      chk_rng("vato_at", VAT, VAT + 4, tea_at);
      chk_err(32'h10, 32'(1) << ST_OFFB_BIT);
      vat_inf = 1'b1;
      grant_dly = 150;
      run_cyc(2'h0, 1'b1, 1'b0, 2'h2, -1, 300);
      chk_rng("vinf_tea", -1, -1, tea_at);
      chk_rng("vinf_ack", 150, 200, ack_at);
      vat_inf = 1'b0;
   endtask

   task t_berr_gvt;
      grant_dly = 2;
      bm = 1'b1;
      d1 = 1'b1;
      run_cyc(2'h0, 1'b1, 1'b0, 2'h2, -1, 100);
      chk_rng("berr_at", 5, 20, tea_at);
      chk_err(32'h04, 32'(1) << ST_OFFB_BIT);
      bm = 1'b0;
      dtack_dly = 100;
      run_cyc(2'h0, 1'b1, 1'b0, 2'h2, -1, 200);
      chk_rng("gvto_at", GVT, GVT + 20, tea_at);
      chk_err(32'h08, 32'(1) << ST_OFFB_BIT);
      gvt_en = 1'b0;
      d1 = 1'b0;
      run_cyc(2'h0, 1'b1, 1'b0, 2'h2, -1, 200);
      chk_rng("gdis_tea", -1, -1, tea_at);
      chk_rng("gdis_ack", 100, 130, ack_at);
      gvt_en = 1'b1;
   endtask

   task t_csr_par;
      for (int k = 0; k < 2; k++) begin
         run_cyc(2'h0, 1'b0, 1'b1, k ? SZ_WORD : SZ_BYTE, 5, 20);
         chk_rng("csr_tea", 0, 0, tea_at);
         chk_err(32'h01, 32'h0);
      end
      run_cyc(2'h0, 1'b0, 1'b1, 2'h2, 5, 20);
      chk_rng("csr_long", 5, 5, ack_at);
      par_err = 1'b1;
      run_cyc(2'h0, 1'b0, 1'b0, 2'h2, 5, 20);
      chk_rng("par_tea", 0, 5, tea_at);
      chk_err(32'h02, 32'(1) << ST_PAR_BIT);
      par_en = 1'b0;
      run_cyc(2'h0, 1'b0, 1'b0, 2'h2, 5, 20);
      chk_rng("par_off", 5, 5, ack_at);
      par_err = 1'b0;
   endtask

   task t_slave;
      int i;
      @(negedge clk);
      slv_dec = 1'b1;
      slv_ds = 1'b1;
      @(negedge clk);
      chk_vec("slv_req", 32'h1, 32'(slv_req));
      slv_gnt = 1'b1;
      repeat (3) @(negedge clk);
      slv_ack = 1'b1;
      @(negedge clk);
      slv_ack = 1'b0;
      chk_vec("dtack_oe", 32'h1, 32'(dt_oe));
      chk_vec("dtack_wire", 32'h0, 32'(dtack_n));
      slv_ds = 1'b0;
      slv_dec = 1'b0;
      slv_gnt = 1'b0;
      for (i = 0; i < 12 && dt_oe === 1'b1; i++)
         @(negedge clk);
      chk_rng("dtack_free", 3, 8, i);
      // Memory never answers: the slave timer must abandon the access
      @(negedge clk);
      slv_dec = 1'b1;
      @(negedge clk);
      slv_gnt = 1'b1;
      repeat (LBT) @(negedge clk);
      chk_vec("slv_hold", 32'h1, 32'(slv_req));
      @(negedge clk);
      slv_dec = 1'b0;
      slv_gnt = 1'b0;
      chk_vec("slv_abandon", 32'h0, 32'({slv_req, dt_oe}));
   endtask

   initial begin
      {failures, n_compared, cycles, grant_dly, dtack_dly} = '0;
      {slv_dec, slv_gnt, slv_ack, slv_ds, bm, d1, par_err, cpu_clr, vat_inf} = '0;
      {rst, gvt_en, par_en, ce} = 4'hf;
      lcyc = '0;
      lmst = 2'h0;
      cause_clr = 4'h0;
      repeat (10) @(negedge clk);
      chk_vec("reset", 32'h0, 32'({cpu_st, breq, dt_oe, slv_req}));
      rst = 1'b0;
      t_local();
      t_ce();
      t_vme();
      t_berr_gvt();
      t_csr_par();
      t_slave();
      stop_test();
   end
endmodule
